//--- hdl/kmc_map.svh
// Port addresses, command codes, field positions, reset values and timing for the command block
`ifndef KMC_MAP_SVH
`define KMC_MAP_SVH

// Host I/O port addresses
`define KMC_PORT_DATA 8'h60
`define KMC_PORT_CMD 8'h64

// Command codes
`define KMC_CMD_RD_CFG 8'h20
`define KMC_CMD_WR_CFG 8'h60
`define KMC_CMD_POLL_HI 8'hC2
`define KMC_CMD_UNPROT 8'hC8
`define KMC_CMD_PROT 8'hC9
`define KMC_CMD_RD_MODE 8'hCA
`define KMC_CMD_RD_OUTP 8'hD0
`define KMC_CMD_WR_OUTP 8'hD1
`define KMC_CMD_WR_KBUF 8'hD2
`define KMC_CMD_WR_ABUF 8'hD3
`define KMC_CMD_WR_AUX 8'hD4
`define KMC_CMD_RD_TEST 8'hE0
`define KMC_NIB_SET 4'hE
`define KMC_NIB_PULSE 4'hF

// Configuration byte fields
`define KMC_CFG_RESET 8'h40
`define KMC_CFG_WMASK 8'h7F
`define KMC_CFG_CONV 6
`define KMC_CFG_AUX_OFF 5
`define KMC_CFG_KBD_OFF 4
`define KMC_CFG_INH_OFF 3
`define KMC_CFG_SYSFLAG 2
`define KMC_CFG_AUX_IRQ 1
`define KMC_CFG_KBD_IRQ 0

// Output port fields and reset value
`define KMC_OUTP_RESET 8'h00
`define KMC_OUTP_RST 0
`define KMC_OUTP_A20 1
`define KMC_OUTP_AUX_DATA 2
`define KMC_OUTP_AUX_CLK 3

// Scan conversion
`define KMC_BREAK_PREFIX 8'hF0
`define KMC_BREAK_BIT 8'h80

// Low pulse on the output lines
`define KMC_CLK_NS 40
`define KMC_PULSE_NS 6000
`define KMC_PULSE_CYC ((`KMC_PULSE_NS + `KMC_CLK_NS - 1) / `KMC_CLK_NS)

// Serial frame on the auxiliary link: start, eight data, parity, stop
`define KMC_FRAME_BITS 4'd11

`endif

//--- hdl/kmc_pkg.sv
// Types shared by the keyboard and mouse command block
package kmc_pkg;

    typedef enum logic [2:0] {
        KMC_IDLE,
        KMC_WAIT_CFG,
        KMC_WAIT_OUTP,
        KMC_WAIT_KBUF,
        KMC_WAIT_ABUF,
        KMC_WAIT_AUX,
        KMC_AUX_BUSY
    } kmc_state_t;

    typedef struct packed {
        kmc_state_t st;
        logic [7:0] ibuf;
        logic ibf;
        logic last_cmd;
        logic [7:0] obuf;
        logic obf;
        logic aux_flag;
        logic [7:0] cfg;
        logic [7:0] outp;
        logic unprot;
        logic poll;
        logic [2:0] poll_val;
        logic [3:0] pulse_mask;
        logic [7:0] pulse_cnt;
        logic [7:0] aux_byte;
        logic aux_req;
        logic kb_pend;
        logic [7:0] kb_byte;
        logic kb_ack;
        logic brk;
        logic [6:0] meta;
        logic [6:0] sync;
        logic [7:0] rdata;
        logic rst_out;
        logic a20_out;
        logic aux_data_out;
        logic aux_clk_out;
        logic kbd_irq;
        logic aux_irq;
    } kmc_main_t;

    typedef struct packed {
        logic rst_m;
        logic rst_s;
        logic req_m;
        logic req_s;
        logic req_seen;
        logic [10:0] sh;
        logic [3:0] cnt;
        logic active;
        logic tx_bit;
        logic ack;
        logic kb_req;
        logic [7:0] kb_hold;
        logic kb_ack_m;
        logic kb_ack_s;
    } kmc_link_t;

endpackage

//--- hdl/kmc_cmd_ctrl.sv
// Host command interpreter of the keyboard and mouse controller, with its auxiliary link end
`timescale 1ns/1ps
`default_nettype none
`include "kmc_map.svh"

// Function
// - Command C2h copies inputs P15-P17 into status bits 5-7 while polling.
// - C8h unprotects output bits 2-3 for output writes; C9h protects them again.
// - CAh posts a mode byte; bit 0 set means PS/2 mode.
// - D0h posts the current output port byte to the data port.
// - D1h loads the next data byte into the output port.
// - D2h posts the next data byte as keyboard data, clearing status bit 5.
// - D3h posts the next data byte as mouse data, setting status bit 5.
// - D4h sends the next data byte to the mouse over the serial link.
// - E0h posts a byte holding keyboard and mouse clock test inputs in bits 0-1.
// - Commands Exh other than E0h set output lines P21-P23 from command bits 1-3.
// - Commands Fxh pulse selected output lines P20-P23 low for 6 us.
// - Unknown command codes are consumed and ignored.
// - Command 60h followed by a data byte writes the configuration byte.
// - Command 20h posts the configuration byte to the data port.
// - Config bit 6 converts two-byte break sequences into one-byte break codes.
// - Config bits 5, 4, 3 drive the mouse, keyboard and inhibit-off levels; only bit 4 acts inside, dropping received keyboard bytes.
// - Config bit 2 reads back as status bit 2.
// - Config bit 1 enables the mouse interrupt on mouse buffer writes.
// - Config bit 0 enables the keyboard interrupt on keyboard buffer writes.
// - Output port bit 0 drives system reset, bit 1 the address-20 gate.
// - Status bit 0 shows a byte waiting in the output buffer.
// - Host writes to port 64h are taken as command codes.
module kmc_cmd_ctrl #(
    parameter logic MODE_PS2 = 1'b1
) (
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Host I/O port access
    input wire logic [7:0] io_addr,
    input wire logic io_wr_stb,
    input wire logic io_rd_stb,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // Asynchronous input pins
    input wire logic [2:0] in_port_hi,
    input wire logic test_kbd_clk_in,
    input wire logic test_aux_clk_in,
    // Output port lines and interrupts
    output logic system_reset_out,
    output logic addr20_gate,
    output logic out_bit2_aux_data,
    output logic out_bit3_aux_clk,
    output logic kbd_interrupt_line,
    output logic aux_interrupt_line,
    // Configuration levels
    output logic scan_convert_en,
    output logic aux_port_off,
    output logic kbd_port_off,
    output logic inhibit_func_off,
    // Link side
    input wire logic link_clk,
    input wire logic kbd_rx_valid,
    input wire logic [7:0] kbd_rx_byte,
    output logic aux_tx_bit,
    output logic aux_tx_active
);

    kmc_pkg::kmc_main_t q_r;
    kmc_pkg::kmc_main_t q_nxt;
    kmc_pkg::kmc_link_t l_r;
    kmc_pkg::kmc_link_t l_nxt;

    logic [7:0] status;
    logic [7:0] eff_port;
    logic post_en;
    logic [7:0] post_byte;
    logic post_aux;

    // Synchronised pins: [2:0] P15-P17, [3] T0, [4] T1, [5] aux ack, [6] keyboard request
    wire logic [2:0] pin_hi = q_r.sync[2:0];
    wire logic t0_s = q_r.sync[3];
    wire logic t1_s = q_r.sync[4];
    wire logic aux_ack_s = q_r.sync[5];
    wire logic kb_req_s = q_r.sync[6];

    // Status byte as the host sees it at the command port
    always_comb begin
        status = 8'h00;
        status[0] = q_r.obf;
        status[1] = q_r.ibf;
        status[2] = q_r.cfg[`KMC_CFG_SYSFLAG];
        status[3] = q_r.last_cmd;
        // No keylock switch here, so the keyboard always reads as free
        status[4] = 1'b1;
        // Polling borrows the top bits and hides the aux flag meanwhile
        status[7:5] = q_r.poll ? q_r.poll_val : {2'b00, q_r.aux_flag};
    end

    always_comb begin
        q_nxt = q_r;
        post_en = 1'b0;
        post_byte = 8'h00;
        post_aux = 1'b0;
        eff_port = 8'h00;

        // Two flip-flops on every pin and on both link handshakes
        q_nxt.meta = {l_r.kb_req, l_r.ack, test_aux_clk_in, test_kbd_clk_in, in_port_hi};
        q_nxt.sync = q_r.meta;

        if (q_r.poll) begin
            q_nxt.poll_val = pin_hi;
        end

        // Low pulse timer
        if (q_r.pulse_cnt != 8'h00) begin
            q_nxt.pulse_cnt = q_r.pulse_cnt - 8'h01;
            if (q_r.pulse_cnt == 8'h01) begin
                q_nxt.pulse_mask = 4'h0;
            end
        end

        // Consume the input buffer
        if (q_r.ibf && q_r.st != kmc_pkg::KMC_AUX_BUSY) begin
            q_nxt.ibf = 1'b0;
            if (q_r.last_cmd) begin
                // A command always cancels a pending data phase
                q_nxt.st = kmc_pkg::KMC_IDLE;
                q_nxt.poll = 1'b0;
                unique case (q_r.ibuf)
                    `KMC_CMD_RD_CFG: begin
                        post_en = 1'b1;
                        post_byte = q_r.cfg;
                    end
                    `KMC_CMD_WR_CFG: begin
                        q_nxt.st = kmc_pkg::KMC_WAIT_CFG;
                    end
                    `KMC_CMD_POLL_HI: begin
                        q_nxt.poll = 1'b1;
                    end
                    `KMC_CMD_UNPROT: begin
                        q_nxt.unprot = 1'b1;
                    end
                    `KMC_CMD_PROT: begin
                        q_nxt.unprot = 1'b0;
                    end
                    `KMC_CMD_RD_MODE: begin
                        post_en = 1'b1;
                        post_byte = {7'h00, MODE_PS2};
                    end
                    `KMC_CMD_RD_OUTP: begin
                        post_en = 1'b1;
                        post_byte = q_r.outp;
                    end
                    `KMC_CMD_WR_OUTP: begin
                        q_nxt.st = kmc_pkg::KMC_WAIT_OUTP;
                    end
                    `KMC_CMD_WR_KBUF: begin
                        q_nxt.st = kmc_pkg::KMC_WAIT_KBUF;
                    end
                    `KMC_CMD_WR_ABUF: begin
                        q_nxt.st = kmc_pkg::KMC_WAIT_ABUF;
                    end
                    `KMC_CMD_WR_AUX: begin
                        q_nxt.st = kmc_pkg::KMC_WAIT_AUX;
                    end
                    `KMC_CMD_RD_TEST: begin
                        post_en = 1'b1;
                        post_byte = {6'h00, t1_s, t0_s};
                    end
                    default: begin
                        if (q_r.ibuf[7:4] == `KMC_NIB_SET) begin
                            // Output bit 0 is left alone; only bits 1-3 follow the command
                            q_nxt.outp[3:1] = q_r.ibuf[3:1];
                        end else if (q_r.ibuf[7:4] == `KMC_NIB_PULSE && q_r.ibuf[3:0] != 4'hF) begin
                            // A cleared command bit selects its line
                            q_nxt.pulse_mask = ~q_r.ibuf[3:0];
                            q_nxt.pulse_cnt = 8'(`KMC_PULSE_CYC);
                        end
                        // Anything else is dropped without effect
                    end
                endcase
            end else begin
                q_nxt.st = kmc_pkg::KMC_IDLE;
                unique case (q_r.st)
                    kmc_pkg::KMC_WAIT_CFG: begin
                        q_nxt.cfg = q_r.ibuf & `KMC_CFG_WMASK;
                    end
                    kmc_pkg::KMC_WAIT_OUTP: begin
                        // Aux lines keep their value unless unprotected
                        if (q_r.unprot) begin
                            q_nxt.outp = q_r.ibuf;
                        end else begin
                            q_nxt.outp = {q_r.ibuf[7:4], q_r.outp[3:2], q_r.ibuf[1:0]};
                        end
                    end
                    kmc_pkg::KMC_WAIT_KBUF: begin
                        post_en = 1'b1;
                        post_byte = q_r.ibuf;
                    end
                    kmc_pkg::KMC_WAIT_ABUF: begin
                        post_en = 1'b1;
                        post_byte = q_r.ibuf;
                        post_aux = 1'b1;
                    end
                    kmc_pkg::KMC_WAIT_AUX: begin
                        // Hold the buffer full until the link has sent the byte
                        q_nxt.aux_byte = q_r.ibuf;
                        q_nxt.aux_req = ~q_r.aux_req;
                        q_nxt.st = kmc_pkg::KMC_AUX_BUSY;
                        q_nxt.ibf = 1'b1;
                    end
                    default: begin
                        // Plain data with no pending command has no keyboard to go to here
                        q_nxt.st = kmc_pkg::KMC_IDLE;
                    end
                endcase
            end
        end

        // Link has acknowledged the frame, so the input buffer is free again
        if (q_r.st == kmc_pkg::KMC_AUX_BUSY && aux_ack_s == q_r.aux_req) begin
            q_nxt.ibf = 1'b0;
            q_nxt.st = kmc_pkg::KMC_IDLE;
        end

        // Take a received keyboard byte from the link
        if (kb_req_s != q_r.kb_ack && !q_r.kb_pend) begin
            q_nxt.kb_byte = l_r.kb_hold;
            q_nxt.kb_pend = 1'b1;
            q_nxt.kb_ack = ~q_r.kb_ack;
        end

        // Host port read: data, status or zero
        if (io_rd_stb) begin
            unique case (io_addr)
                `KMC_PORT_DATA: begin
                    q_nxt.rdata = q_r.obuf;
                    q_nxt.obf = 1'b0;
                end
                `KMC_PORT_CMD: begin
                    q_nxt.rdata = status;
                end
                default: begin
                    // Unused ports read as zero
                    q_nxt.rdata = 8'h00;
                end
            endcase
        end

        // Posting: command answers first, keyboard bytes only into an empty buffer
        if (post_en) begin
            q_nxt.obuf = post_byte;
            q_nxt.obf = 1'b1;
            q_nxt.aux_flag = post_aux;
        end else if (q_r.kb_pend && !q_r.obf) begin
            q_nxt.kb_pend = 1'b0;
            if (q_r.cfg[`KMC_CFG_KBD_OFF]) begin
                q_nxt.brk = 1'b0;
            end else if (q_r.cfg[`KMC_CFG_CONV] && q_r.kb_byte == `KMC_BREAK_PREFIX) begin
                q_nxt.brk = 1'b1;
            end else begin
                if (q_r.cfg[`KMC_CFG_CONV] && q_r.brk) begin
                    q_nxt.obuf = q_r.kb_byte | `KMC_BREAK_BIT;
                end else begin
                    q_nxt.obuf = q_r.kb_byte;
                end
                q_nxt.brk = 1'b0;
                q_nxt.obf = 1'b1;
                q_nxt.aux_flag = 1'b0;
            end
        end

        // Host write wins over consumption in the same cycle
        if (io_wr_stb && (io_addr == `KMC_PORT_DATA || io_addr == `KMC_PORT_CMD)) begin
            q_nxt.ibuf = io_wdata;
            q_nxt.ibf = 1'b1;
            q_nxt.last_cmd = (io_addr == `KMC_PORT_CMD);
        end

        // Pins follow the next state so each output leaves a flip-flop
        eff_port = q_nxt.outp & ~{4'h0, q_nxt.pulse_mask};
        q_nxt.rst_out = eff_port[`KMC_OUTP_RST];
        q_nxt.a20_out = eff_port[`KMC_OUTP_A20];
        q_nxt.aux_data_out = eff_port[`KMC_OUTP_AUX_DATA];
        q_nxt.aux_clk_out = eff_port[`KMC_OUTP_AUX_CLK];
        q_nxt.kbd_irq = q_nxt.obf & ~q_nxt.aux_flag & q_nxt.cfg[`KMC_CFG_KBD_IRQ];
        q_nxt.aux_irq = q_nxt.obf & q_nxt.aux_flag & q_nxt.cfg[`KMC_CFG_AUX_IRQ];

        if (!resetn) begin
            q_nxt = '0;
            q_nxt.st = kmc_pkg::KMC_IDLE;
            q_nxt.cfg = `KMC_CFG_RESET;
            q_nxt.outp = `KMC_OUTP_RESET;
        end
    end

    always_ff @(posedge clk) begin
        q_r <= q_nxt;
    end

    // Link domain: reset is resynchronised, so resetn must cover a few link edges
    always_comb begin
        l_nxt = l_r;
        l_nxt.rst_m = resetn;
        l_nxt.rst_s = l_r.rst_m;
        l_nxt.req_m = q_r.aux_req;
        l_nxt.req_s = l_r.req_m;
        l_nxt.kb_ack_m = q_r.kb_ack;
        l_nxt.kb_ack_s = l_r.kb_ack_m;

        if (l_r.active) begin
            l_nxt.tx_bit = l_r.sh[0];
            l_nxt.sh = {1'b1, l_r.sh[10:1]};
            l_nxt.cnt = l_r.cnt - 4'd1;
            // Active drops once the stop bit has stood for a link cycle
            if (l_r.cnt == 4'd1) begin
                l_nxt.active = 1'b0;
                l_nxt.ack = l_r.req_seen;
            end
        end else begin
            l_nxt.tx_bit = 1'b1;
            if (l_r.req_s != l_r.req_seen) begin
                // Byte is stable on the system side until the ack returns
                // Start bit leaves with the load so the line lines up with active
                l_nxt.tx_bit = 1'b0;
                l_nxt.sh = {2'b11, ~^q_r.aux_byte, q_r.aux_byte};
                l_nxt.cnt = `KMC_FRAME_BITS;
                l_nxt.active = 1'b1;
                l_nxt.req_seen = l_r.req_s;
            end
        end

        // One byte in flight; a byte arriving while the last is unacknowledged is lost
        if (kbd_rx_valid && l_r.kb_req == l_r.kb_ack_s) begin
            l_nxt.kb_hold = kbd_rx_byte;
            l_nxt.kb_req = ~l_r.kb_req;
        end

        if (!l_r.rst_s) begin
            l_nxt.req_seen = 1'b0;
            l_nxt.sh = 11'h7FF;
            l_nxt.cnt = 4'd0;
            l_nxt.active = 1'b0;
            l_nxt.tx_bit = 1'b1;
            l_nxt.ack = 1'b0;
            l_nxt.kb_req = 1'b0;
            l_nxt.kb_hold = 8'h00;
            l_nxt.req_m = 1'b0;
            l_nxt.req_s = 1'b0;
            l_nxt.kb_ack_m = 1'b0;
            l_nxt.kb_ack_s = 1'b0;
        end
    end

    always_ff @(posedge link_clk) begin
        l_r <= l_nxt;
    end

    assign io_rdata = q_r.rdata;
    assign system_reset_out = q_r.rst_out;
    assign addr20_gate = q_r.a20_out;
    assign out_bit2_aux_data = q_r.aux_data_out;
    assign out_bit3_aux_clk = q_r.aux_clk_out;
    assign kbd_interrupt_line = q_r.kbd_irq;
    assign aux_interrupt_line = q_r.aux_irq;
    assign scan_convert_en = q_r.cfg[`KMC_CFG_CONV];
    assign aux_port_off = q_r.cfg[`KMC_CFG_AUX_OFF];
    assign kbd_port_off = q_r.cfg[`KMC_CFG_KBD_OFF];
    assign inhibit_func_off = q_r.cfg[`KMC_CFG_INH_OFF];
    assign aux_tx_bit = l_r.tx_bit;
    assign aux_tx_active = l_r.active;

endmodule
`default_nettype wire

//--- tb/kmc_cmd_ctrl_chk.sv
// Port assertions for the keyboard and mouse command block
`timescale 1ns/1ps
`default_nettype none
module kmc_cmd_ctrl_chk (
    // System clock and reset
    input wire logic clk,
    input wire logic resetn,
    // Host port access
    input wire logic [7:0] io_addr,
    input wire logic io_wr_stb,
    input wire logic io_rd_stb,
    input wire logic [7:0] io_rdata,
    // Output lines and levels
    input wire logic addr20_gate,
    input wire logic kbd_interrupt_line,
    input wire logic aux_interrupt_line,
    input wire logic scan_convert_en,
    input wire logic aux_port_off,
    input wire logic kbd_port_off,
    input wire logic inhibit_func_off,
    // Link side
    input wire logic link_clk,
    input wire logic aux_tx_bit,
    input wire logic aux_tx_active
);
    unmapped_rd_a: assert property (@(posedge clk) disable iff (!resetn)
        io_rd_stb && io_addr != 8'h60 && io_addr != 8'h64 |=> io_rdata == 8'h00)
        else $error("unused port read returned data");
    rdata_hold_a: assert property (@(posedge clk) disable iff (!resetn)
        !io_rd_stb |=> $stable(io_rdata))
        else $error("read data moved without a read");
    irq_excl_a: assert property (@(posedge clk) disable iff (!resetn)
        !(kbd_interrupt_line && aux_interrupt_line))
        else $error("both interrupt lines high");
    rd_clear_a: assert property (@(posedge clk) disable iff (!resetn)
        io_rd_stb && io_addr == 8'h60 |-> ##[1:2] !kbd_interrupt_line && !aux_interrupt_line)
        else $error("interrupt stayed after data read");
    cfg_cause_a: assert property (@(posedge clk) disable iff (!resetn)
        $changed({scan_convert_en, aux_port_off, kbd_port_off, inhibit_func_off})
        |-> $past(io_wr_stb, 2) || $past(io_wr_stb, 3) || $past(io_wr_stb, 4))
        else $error("config lines changed with no write");
    a20_cause_a: assert property (@(posedge clk) disable iff (!resetn)
        $changed(addr20_gate) |-> $past(io_wr_stb, 2) || $past(io_wr_stb, 3) || $past(io_wr_stb, 4))
        else $error("address gate changed with no write");
    frame_a: assert property (@(posedge link_clk) disable iff (!resetn)
        $rose(aux_tx_active) |-> !aux_tx_bit ##1 aux_tx_active [*8] ##2 aux_tx_active && aux_tx_bit
        ##1 !aux_tx_active)
        else $error("bad aux frame shape");
    idle_a: assert property (@(posedge link_clk) disable iff (!resetn)
        !aux_tx_active |-> aux_tx_bit)
        else $error("aux line low outside a frame");
endmodule

bind kmc_cmd_ctrl kmc_cmd_ctrl_chk u_chk (.clk, .resetn, .io_addr, .io_wr_stb, .io_rd_stb, .io_rdata,
    .addr20_gate, .kbd_interrupt_line, .aux_interrupt_line, .scan_convert_en, .aux_port_off,
    .kbd_port_off, .inhibit_func_off, .link_clk, .aux_tx_bit, .aux_tx_active);
`default_nettype wire

//--- tb/kmc_dev_model.sv
// Keyboard and mouse device model on the link side
`timescale 1ns/1ps
`default_nettype none
module kmc_dev_model (
    // Link clock and serial line from the block
    input wire logic link_clk,
    input wire logic aux_tx_bit,
    input wire logic aux_tx_active,
    // Keyboard bytes into the block
    output logic kbd_rx_valid,
    output logic [7:0] kbd_rx_byte
);
    logic [10:0] shift, frame_got;
    logic [3:0] nbits;
    int ngot;

    initial begin
        kbd_rx_valid = 1'h0;
        kbd_rx_byte = 8'h00;
        shift = 11'h000;
        frame_got = 11'h000;
        nbits = 4'h0;
        ngot = 0;
    end

    // Whole frame kept so start, parity and stop are judged too
    always @(posedge link_clk) begin
        if (aux_tx_active) begin
            shift <= {aux_tx_bit, shift[10:1]};
            nbits <= nbits + 4'h1;
        end else if (nbits != 4'h0) begin
            frame_got <= shift;
            ngot <= ngot + 1;
            nbits <= 4'h0;
        end
    end

    // Byte is not left on the bus after its strobe
    task automatic send_key(input logic [7:0] b);
        @(negedge link_clk);
        kbd_rx_valid = 1'h1;
        kbd_rx_byte = b;
        @(negedge link_clk);
        kbd_rx_valid = 1'h0;
        kbd_rx_byte = ~b;
        repeat (8) @(negedge link_clk);
    endtask
endmodule
`default_nettype wire

//--- tb/test_ps2_kbd_mouse_controller_cmds.sv
// Self-checking bench for the keyboard and mouse command block
`timescale 1ns/1ps
`default_nettype none
module test_ps2_kbd_mouse_controller_cmds;
    logic clk, resetn, link_clk, io_wr_stb, io_rd_stb, test_kbd_clk_in, test_aux_clk_in;
    logic system_reset_out, addr20_gate, out_bit2_aux_data, out_bit3_aux_clk, kbd_interrupt_line;
    logic aux_interrupt_line, scan_convert_en, aux_port_off, kbd_port_off, inhibit_func_off;
    logic kbd_rx_valid, aux_tx_bit, aux_tx_active;
    logic [7:0] io_addr, io_wdata, io_rdata, kbd_rx_byte, st;
    logic [2:0] in_port_hi;
    int n_errors, checks;
    wire [3:0] outl = {out_bit3_aux_clk, out_bit2_aux_data, addr20_gate, system_reset_out};
    wire [3:0] cfgl = {scan_convert_en, aux_port_off, kbd_port_off, inhibit_func_off};

    kmc_cmd_ctrl uut (.clk, .resetn, .io_addr, .io_wr_stb, .io_rd_stb, .io_wdata, .io_rdata, .in_port_hi,
        .test_kbd_clk_in, .test_aux_clk_in, .system_reset_out, .addr20_gate, .out_bit2_aux_data,
        .out_bit3_aux_clk, .kbd_interrupt_line, .aux_interrupt_line, .scan_convert_en, .aux_port_off,
        .kbd_port_off, .inhibit_func_off, .link_clk, .kbd_rx_valid, .kbd_rx_byte, .aux_tx_bit,
        .aux_tx_active);
    kmc_dev_model dev (.link_clk, .aux_tx_bit, .aux_tx_active, .kbd_rx_valid, .kbd_rx_byte);

    initial begin
        clk = 1'h0;
        forever #20 clk = ~clk;
    end
    initial begin
        link_clk = 1'h0;
        #7;
        forever #62.5 link_clk = ~link_clk;
    end

    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic wrap_up;
        $display("checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic io_wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_wdata = d;
        io_wr_stb = 1'h1;
        @(negedge clk);
        io_wr_stb = 1'h0;
    endtask

    task automatic io_rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        io_addr = a;
        io_rd_stb = 1'h1;
        @(negedge clk);
        io_rd_stb = 1'h0;
        @(negedge clk);
        d = io_rdata;
    endtask

    // Polls status; a long aux transfer keeps the input buffer full
    task automatic wait_st(input int n, input logic v);
        for (int i = 0; i < 400; i++) begin
            io_rd(8'h64, st);
            if (st[n] === v) return;
        end
        check("status wait", st[n], v);
        wrap_up();
    endtask

    task automatic cmd(input logic [7:0] c);
        io_wr(8'h64, c);
        wait_st(1, 1'h0);
    endtask

    task automatic dat(input logic [7:0] d);
        io_wr(8'h60, d);
        wait_st(1, 1'h0);
    endtask

    task automatic answer(input string what, input logic [7:0] exp);
        wait_st(0, 1'h1);
        io_rd(8'h60, st);
        check(what, st, exp);
    endtask

    initial begin
        n_errors = 0;
        checks = 0;
        resetn = 1'h0;
        io_wr_stb = 1'h0;
        io_rd_stb = 1'h0;
        io_addr = 8'h00;
        io_wdata = 8'h00;
        in_port_hi = 3'h0;
        test_kbd_clk_in = 1'h0;
        test_aux_clk_in = 1'h0;
        // Ten cycles give the slow link clock the three edges its reset needs
        repeat (10) @(negedge clk);
        resetn = 1'h1;
        io_rd(8'h64, st);
        check("status", st, 8'h10);
        check("cfg lines", cfgl, 4'h8);
        io_rd(8'h61, st);
        check("unused port", st, 8'h00);
        dat(8'h55);
        cmd(8'hA5);
        io_rd(8'h64, st);
        check("status", st, 8'h18);
        cmd(8'h60);
        dat(8'hFF);
        check("cfg lines", cfgl, 4'hF);
        io_rd(8'h64, st);
        check("system flag", st[2], 1'h1);
        cmd(8'h20);
        answer("cfg", 8'h7F);
        cmd(8'h60);
        dat(8'h43);
        check("cfg lines", cfgl, 4'h8);
        cmd(8'hCA);
        answer("mode", 8'h01);
        cmd(8'hD1);
        dat(8'h0F);
        check("out lines", outl, 4'h3);
        cmd(8'hC8);
        cmd(8'hD1);
        dat(8'h0F);
        check("out lines", outl, 4'hF);
        cmd(8'hC9);
        cmd(8'hD1);
        dat(8'h03);
        check("out lines", outl, 4'hF);
        cmd(8'hD0);
        answer("out port", 8'h0F);
        cmd(8'hEA);
        check("out lines", outl, 4'hB);
        cmd(8'hE4);
        check("out lines", outl, 4'h5);
        cmd(8'hFE);
        check("out lines", outl, 4'h4);
        repeat (120) @(negedge clk);
        check("out lines", outl, 4'h4);
        repeat (40) @(negedge clk);
        check("out lines", outl, 4'h5);
        for (int i = 1; i < 3; i++) begin
            {test_aux_clk_in, test_kbd_clk_in} = 2'(i);
            repeat (4) @(negedge clk);
            cmd(8'hE0);
            answer("test inputs", 8'(i));
        end
        for (int i = 0; i < 2; i++) begin
            cmd(8'hD2 + 8'(i));
            dat(8'h5A + 8'(i));
            io_rd(8'h64, st);
            check("buffer flags", {st[5], st[0]}, {1'(i), 1'h1});
            check("irq lines", {kbd_interrupt_line, aux_interrupt_line}, i ? 2'h1 : 2'h2);
            answer("posted", 8'h5A + 8'(i));
            repeat (2) @(negedge clk);
            check("irq lines", {kbd_interrupt_line, aux_interrupt_line}, 2'h0);
        end
        in_port_hi = 3'h5;
        cmd(8'hC2);
        for (int i = 0; i < 2; i++) begin
            repeat (4) @(negedge clk);
            io_rd(8'h64, st);
            check("polled", st[7:5], in_port_hi);
            in_port_hi = 3'h2;
        end
        cmd(8'hD4);
        dat(8'h96);
        // The model files the frame one link edge after the ack
        repeat (2) @(negedge link_clk);
        check("aux frame", dev.frame_got, {1'h1, ~^8'h96, 8'h96, 1'h0});
        check("aux frames", 8'(dev.ngot), 8'h01);
        dev.send_key(8'hF0);
        dev.send_key(8'h1C);
        answer("break code", 8'h9C);
        cmd(8'h60);
        dat(8'h01);
        dev.send_key(8'h33);
        answer("raw code", 8'h33);
        cmd(8'h60);
        dat(8'h10);
        dev.send_key(8'h44);
        repeat (40) @(negedge clk);
        io_rd(8'h64, st);
        check("kbd off", {kbd_port_off, st[0]}, 2'h2);
        wrap_up();
    end

    initial begin
        repeat (100000) @(posedge clk);
        check("run time", 1'h0, 1'h1);
        wrap_up();
    end
endmodule
`default_nettype wire
